//--- hdl/sgm_consts.vh
`ifndef SGM_CONSTS_VH
`define SGM_CONSTS_VH
// ----------------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define SGM_IDX_CTRL     4'h0
`define SGM_IDX_RSTAT    4'h1
`define SGM_IDX_SWC0     4'h2
`define SGM_IDX_SWC3     4'h5
`define SGM_IDX_IDHI     4'h6
`define SGM_IDX_IDLO     4'h7
`define SGM_IDX_PWR      4'h8
`define SGM_IDX_CLKOUT   4'hA
`define SGM_IDX_ROUTE    4'hB
`define SGM_IDX_PCE      4'hC
`define SGM_IDX_SAHI     4'hD
`define SGM_IDX_SALO     4'hE
// ----------------------------------------------------------------------------
// control register fields and masks
// ----------------------------------------------------------------------------
`define SGM_CTRL_TSD_HI  15
`define SGM_CTRL_TSD_LO  12
`define SGM_CTRL_SERIAL_STOP_CLK_EN  11
`define SGM_CTRL_TC3_IN  9
`define SGM_CTRL_DBGCLK  5
`define SGM_CTRL_SOFT_RESET_TRIGGER   4
`define SGM_CTRL_STOP_HI 3
`define SGM_CTRL_STOP_LO 2
`define SGM_CTRL_WAIT_HI 1
`define SGM_CTRL_WAIT_LO 0
`define SGM_CTRL_MASK    16'hFA2F
`define SGM_CTRL_RST     16'h0000
`define SGM_RSTAT_SWR    5
`define SGM_RSTAT_COP    4
`define SGM_RSTAT_EXT    3
`define SGM_RSTAT_POR    2
`define SGM_PWR_MASK     16'h0003
`define SGM_CLKOUT_MASK  16'h03FF
`define SGM_CLKOUT_RST   16'h0020
`define SGM_ROUTE_MASK   16'hCFFF
`define SGM_PCE_MASK     16'hA055
`define SGM_PCE_I2C      15
`define SGM_PCE_ADC      13
`define SGM_PCE_TMR      6
`define SGM_PCE_SCI      4
`define SGM_PCE_SPI      2
`define SGM_PCE_PWM      0
`define SGM_SAHI_MASK    16'h0003
// ----------------------------------------------------------------------------
// power modes and timing
// ----------------------------------------------------------------------------
`define SGM_MODE_RUN     2'h0
`define SGM_MODE_WAIT    2'h1
`define SGM_MODE_STOP    2'h2
`define SGM_HS_DIV       3
`define SGM_SOFT_RESET_TRIGGER_NS     400
`define SGM_CLK_NS       100
`define SGM_SOFT_RESET_TRIGGER_CYC    ((`SGM_SOFT_RESET_TRIGGER_NS + `SGM_CLK_NS - 1) / `SGM_CLK_NS)
`endif

//--- hdl/sgm_sys_glue_module.v
`include "sgm_consts.vh"
// Function
// - timer channel stop bits 15..12 keep channel clocks running in Stop
// - serial stop bit 11 keeps the serial unit clock running in Stop
// - bit 9 feeds timer ch3 from PWM reload sync, else pin routing
// - bit 5 clear: debug clock only while TAP enabled; set: always on
// - writing 1 to bit 4 raises sys_rst_req for RESET_HOLD_CYC cycles to request a reset
// - stop field low bit 0 lets stop instruction enter Stop; 1 ignores it
// - stop field high bit written 1 locks the field until reset
// - wait field low bit 0 lets wait instruction enter Wait; 1 ignores it
// - wait field high bit written 1 locks the field until reset
// - Stop halts core, system and peripheral clocks except kept ones
// - Wait halts core and unneeded system clock, peripherals keep running
// - Run keeps everything running; exactly three modes Run, Wait, Stop
// - four 16-bit scratch registers cleared only by power-on reset
// - timer and PWM get an optional triple-rate peripheral clock enable
// - clock enable register gates I2C, converter, timer, serial, SPI, PWM
// - short address held as bits 23:22 high and bits 21:6 low
// - control bits 10 and 8..6 read zero, writes ignored
// - reset status shows one cause: power-on, pin, watchdog, software
// - software reset flag set only when no higher cause occurred
module sgm_sys_glue_module #(
  parameter RESET_HOLD_CYC = `SGM_SOFT_RESET_TRIGGER_CYC,
  parameter [15:0] ID_UPPER = 16'h0A5A,     // arbitrary value
  parameter [15:0] ID_LOWER = 16'h5A0A      // arbitrary value
) (
  // clock and the two reset domains
  input  wire        core_clk,
  input  wire        nrst,
  input  wire        por_nrst,
  input  wire        pin_rst_req,
  input  wire        wdog_rst_req,

  // register bus, zero wait states
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,

  // core halt handshake and pin-level inputs
  input  wire        core_stop_req,
  input  wire        core_wait_req,
  input  wire        wake_req,
  input  wire        tap_enabled,
  input  wire        pwm_reload_sync,
  input  wire        tmr3_pin_in,
  input  wire        hs_clk_sel,

  // power mode and clock enables
  output reg  [1:0]  power_mode,
  output wire        core_clk_en,
  output wire        sys_clk_en,
  output wire        periph_clk_en,
  output wire        hs_periph_tick,
  output wire [3:0]  tmr_ch_clk_en,
  output wire        serial_clk_en,
  output wire        i2c_clk_en,
  output wire        adc_clk_en,
  output wire        spi_clk_en,
  output wire        pwm_clk_en,
  output wire        dbg_clk_en,

  // routing, reset request and configuration
  output wire        tmr_ch3_in,
  output wire        sys_rst_req,
  output wire [17:0] short_addr_loc,
  output wire [1:0]  regulator_standby,
  output wire [15:0] pin_route,
  output wire [9:0]  clkout_ctl
);
  // --------------------------------------------------------------------------
  // bus address phase capture
  // --------------------------------------------------------------------------
  // bus pipeline state and halt-field lock bits
  reg        wr_pend_q;
  reg [3:0]  wr_idx_q;
  reg        stop_lock_q;
  reg        wait_lock_q;

  // configuration registers
  reg [15:0] ctrl_q;
  reg [15:0] rstat_q;
  reg [15:0] scratch_q [0:3];
  reg [15:0] pwr_q;
  reg [15:0] clkout_q;
  reg [15:0] route_q;
  reg [15:0] pce_q;
  reg [15:0] sahi_q;
  reg [15:0] salo_q;

  // counters
  reg [7:0]  rst_cnt_q;
  reg [1:0]  hs_cnt_q;

  // combinational helper
  reg [15:0] ctrl_d;

  // an access is a selected, non-idle transfer while the bus is ready
  wire       acc    = hsel && hready && htrans[1];
  wire [3:0] a_idx  = haddr[5:2];
  wire       wr_now = wr_pend_q;
  wire [15:0] wdat  = hwdata[15:0];
  wire       sw_rst_fire = wr_now && (wr_idx_q == `SGM_IDX_CTRL) && wdat[`SGM_CTRL_SOFT_RESET_TRIGGER];

  // the slave never stalls: every register answers in the data phase, so
  // the master's second ready sample always falls one edge after the first
  assign hreadyout = 1'b1;                  // zero wait states
  assign hresp     = 1'b0;                  // always OKAY

  // unmapped and reserved indices fall through to zero, so reads never stall
  // index decode used by reads only; writes decode wr_idx_q on their own
  function [15:0] rd_mux;
    input [3:0] idx;
    begin
      if (idx == `SGM_IDX_CTRL) begin
        rd_mux = ctrl_q & `SGM_CTRL_MASK;
      end else if (idx == `SGM_IDX_RSTAT) begin
        rd_mux = rstat_q;
      end else if (idx >= `SGM_IDX_SWC0 && idx <= `SGM_IDX_SWC3) begin
        // scratch words sit at four consecutive indices
        rd_mux = scratch_q[idx[1:0] - 2'h2];
      end else if (idx == `SGM_IDX_IDHI) begin
        rd_mux = ID_UPPER;
      end else if (idx == `SGM_IDX_IDLO) begin
        rd_mux = ID_LOWER;
      end else if (idx == `SGM_IDX_PWR) begin
        rd_mux = pwr_q;
      end else if (idx == `SGM_IDX_CLKOUT) begin
        rd_mux = clkout_q;
      end else if (idx == `SGM_IDX_ROUTE) begin
        rd_mux = route_q;
      end else if (idx == `SGM_IDX_PCE) begin
        rd_mux = pce_q;
      end else if (idx == `SGM_IDX_SAHI) begin
        rd_mux = sahi_q;
      end else if (idx == `SGM_IDX_SALO) begin
        rd_mux = salo_q;
      end else begin
        rd_mux = 16'h0000;                  // unmapped reads zero
      end
    end
  endfunction

  // read data is fetched at the address edge so that it stands through the
  // whole data phase; a write needs hwdata, which only arrives one cycle later
  // address phase: capture write target, register read data
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 4'h0;
      hrdata    <= 32'h0000_0000;
    end else begin
      wr_pend_q <= acc && hwrite;
      wr_idx_q  <= a_idx;
      if (acc && !hwrite) begin
        hrdata <= {16'h0000, rd_mux(a_idx)};
      end
    end
  end

  // --------------------------------------------------------------------------
  // control register with lockable halt-instruction fields
  // --------------------------------------------------------------------------
  // the software reset bit is never stored: it only fires the stretch counter and the reset cause flag
  // below, which is why the bit always reads back as zero
  // next control value; locked fields are kept while the rest updates
  always @* begin
    ctrl_d = ctrl_q;
    if (wr_now && wr_idx_q == `SGM_IDX_CTRL) begin
      ctrl_d = wdat & `SGM_CTRL_MASK & ~(16'h0001 << `SGM_CTRL_SOFT_RESET_TRIGGER);
      // a locked field keeps its stored code; the rest of the word still lands
      if (stop_lock_q) begin
        ctrl_d[`SGM_CTRL_STOP_HI:`SGM_CTRL_STOP_LO] =
          ctrl_q[`SGM_CTRL_STOP_HI:`SGM_CTRL_STOP_LO];
      end
      if (wait_lock_q) begin
        ctrl_d[`SGM_CTRL_WAIT_HI:`SGM_CTRL_WAIT_LO] =
          ctrl_q[`SGM_CTRL_WAIT_HI:`SGM_CTRL_WAIT_LO];
      end
    end
  end

  // lock bits follow the stored high bit of each field; since a locked field
  // keeps that bit set, only nrst can release it again
  // system-reset domain registers (pin, watchdog, software and power-on)
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q      <= `SGM_CTRL_RST;
      stop_lock_q <= 1'b0;
      wait_lock_q <= 1'b0;
      pwr_q       <= 16'h0000;
      clkout_q    <= `SGM_CLKOUT_RST;
      route_q     <= 16'h0000;
      pce_q       <= 16'h0000;
      sahi_q      <= 16'h0000;
      salo_q      <= 16'h0000;
    end else begin
      ctrl_q      <= ctrl_d;
      stop_lock_q <= ctrl_d[`SGM_CTRL_STOP_HI];
      wait_lock_q <= ctrl_d[`SGM_CTRL_WAIT_HI];
      // writes to read-only or unmapped indices fall through and are dropped
      if (wr_now) begin
        if (wr_idx_q == `SGM_IDX_PWR && !pwr_q[1]) begin
          pwr_q <= wdat & `SGM_PWR_MASK;    // regulator field locks itself too
        end else if (wr_idx_q == `SGM_IDX_CLKOUT) begin
          clkout_q <= wdat & `SGM_CLKOUT_MASK;
        end else if (wr_idx_q == `SGM_IDX_ROUTE) begin
          route_q <= wdat & `SGM_ROUTE_MASK;
        end else if (wr_idx_q == `SGM_IDX_PCE) begin
          pce_q <= wdat & `SGM_PCE_MASK;
        end else if (wr_idx_q == `SGM_IDX_SAHI) begin
          sahi_q <= wdat & `SGM_SAHI_MASK;
        end else if (wr_idx_q == `SGM_IDX_SALO) begin
          salo_q <= wdat;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // power-on domain: scratch registers and reset cause
  // --------------------------------------------------------------------------
  // these processes use por_nrst so that a pin, watchdog or software reset
  // cannot disturb what software left here or the recorded cause
  // scratch survives pin, watchdog and software resets by using por only
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_scr
      always @(posedge core_clk or negedge por_nrst) begin
        if (!por_nrst) begin
          scratch_q[gi] <= 16'h0000;
        end else if (wr_now && wr_idx_q == (`SGM_IDX_SWC0 + gi)) begin
          scratch_q[gi] <= wdat;
        end
      end
    end
  endgenerate

  // a later cause overwrites an older one; only one flag is ever shown,
  // so software always reads the most recent reset
  // one cause only; highest precedence wins when several arrive together
  always @(posedge core_clk or negedge por_nrst) begin
    if (!por_nrst) begin
      rstat_q <= 16'h0001 << `SGM_RSTAT_POR;
    end else if (pin_rst_req) begin
      rstat_q <= 16'h0001 << `SGM_RSTAT_EXT;
    end else if (wdog_rst_req) begin
      rstat_q <= 16'h0001 << `SGM_RSTAT_COP;
    end else if (sw_rst_fire) begin
      rstat_q <= 16'h0001 << `SGM_RSTAT_SWR;
    end
  end

  // limitation: the request is only an output; whoever owns nrst must act on it
  // software reset pulse stretched so the whole part sees it
  always @(posedge core_clk or negedge por_nrst) begin
    if (!por_nrst) begin
      rst_cnt_q <= 8'h00;
    end else if (sw_rst_fire) begin
      rst_cnt_q <= RESET_HOLD_CYC[7:0];
    end else if (rst_cnt_q != 8'h00) begin
      rst_cnt_q <= rst_cnt_q - 8'h01;
    end
  end
  assign sys_rst_req = (rst_cnt_q != 8'h00);

  // --------------------------------------------------------------------------
  // power mode sequencer
  // --------------------------------------------------------------------------
  // stop is checked first so a core that raises both requests lands in Stop,
  // the deeper mode; the unused fourth code falls back to Run
  // the mode is registered, so clock enables change one edge after a request
  // wake returns to run; halt requests honoured only when not blocked
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      power_mode <= `SGM_MODE_RUN;
    end else begin
      case (power_mode)
        `SGM_MODE_RUN: begin
          if (core_stop_req && !ctrl_q[`SGM_CTRL_STOP_LO]) begin
            power_mode <= `SGM_MODE_STOP;
          end else if (core_wait_req && !ctrl_q[`SGM_CTRL_WAIT_LO]) begin
            power_mode <= `SGM_MODE_WAIT;
          end
        end
        // both halt modes leave only through a wake request
        `SGM_MODE_WAIT, `SGM_MODE_STOP: begin
          if (wake_req) begin
            power_mode <= `SGM_MODE_RUN;
          end
        end
        default: begin
          power_mode <= `SGM_MODE_RUN;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // clock gating
  // --------------------------------------------------------------------------
  // run: everything on; wait: core and system clock off, peripherals on;
  // stop: all off except timer channels and the serial unit kept alive
  // enables are decoded straight from registers so they change with the mode;
  // downstream gating cells must latch them on the low clock phase
  wire in_stop = (power_mode == `SGM_MODE_STOP);
  wire in_run  = (power_mode == `SGM_MODE_RUN);
  assign core_clk_en   = in_run;
  assign sys_clk_en    = in_run;                                         // unneeded system clock off
  assign periph_clk_en = !in_stop;

  // shared decode: a peripheral enable that may be kept alive in Stop
  function stop_gate;
    input en;
    input keep;
    begin
      stop_gate = en && (!in_stop || keep);
    end
  endfunction

  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_tmr
      assign tmr_ch_clk_en[gi] = pce_q[`SGM_PCE_TMR] &&
        (!in_stop || ctrl_q[`SGM_CTRL_TSD_LO + gi]);
    end
  endgenerate

  assign serial_clk_en = pce_q[`SGM_PCE_SCI] &&
                         (!in_stop || ctrl_q[`SGM_CTRL_SERIAL_STOP_CLK_EN]);
  assign i2c_clk_en = stop_gate(pce_q[`SGM_PCE_I2C], 1'b0);
  assign adc_clk_en = stop_gate(pce_q[`SGM_PCE_ADC], 1'b0);
  assign spi_clk_en = stop_gate(pce_q[`SGM_PCE_SPI], 1'b0);
  assign pwm_clk_en = stop_gate(pce_q[`SGM_PCE_PWM], 1'b0);

  // last divider count, sized to the counter
  localparam [1:0] HS_LAST = `SGM_HS_DIV - 1;

  // a tick pulse instead of a second clock keeps timer and PWM on core_clk
  // the divider runs even in Stop; only its output is masked
  // triple-rate tick is a one-cycle enable; normal rate is every third tick
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hs_cnt_q <= 2'h0;
    end else if (hs_cnt_q == HS_LAST) begin
      hs_cnt_q <= 2'h0;
    end else begin
      hs_cnt_q <= hs_cnt_q + 2'h1;
    end
  end
  assign hs_periph_tick = !in_stop && (hs_clk_sel || hs_cnt_q == 2'h0);

  // --------------------------------------------------------------------------
  // routing and configuration outputs
  // --------------------------------------------------------------------------
  // debug clock ignores the power mode so a halted core stays reachable
  assign dbg_clk_en = ctrl_q[`SGM_CTRL_DBGCLK] || tap_enabled;
  assign tmr_ch3_in = ctrl_q[`SGM_CTRL_TC3_IN] ? pwm_reload_sync
                                               : tmr3_pin_in;

  // the short-address parts are wired out as stored; unused bits read zero
  // the regulator field locks itself like the halt fields, see the write decode
  assign short_addr_loc    = {sahi_q[1:0], salo_q};
  assign regulator_standby = pwr_q[1:0];
  assign pin_route         = route_q;
  assign clkout_ctl        = clkout_q[9:0];
endmodule

//--- verification/sgm_core_model.sv
// ----------------------------------------------------------------------------
// core and software: single word bus transfers and halt requests
// ----------------------------------------------------------------------------
module sgm_core_model (
  input  wire         core_clk,
  input  wire         hready,
  input  wire  [31:0] hrdata,
  output logic        hsel,
  output logic [31:0] haddr,
  output logic [1:0]  htrans,
  output logic        hwrite,
  output logic [2:0]  hsize,
  output logic [31:0] hwdata,
  output logic        core_stop_req,
  output logic        core_wait_req,
  output logic        wake_req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'h2;
    {core_stop_req, core_wait_req, wake_req} = 3'h0;
  end
  // address phase held until ready, then data phase held until ready; released lines toggle
  task automatic xfer(input logic w, input logic [3:0] i, input logic [15:0] wd,
                      output logic [15:0] rd);
    @(posedge core_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {26'h0, i, 2'h0};
    hwrite <= w;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    haddr  <= ~haddr;
    hwdata <= w ? {16'h0, wd} : ~hwdata;
    do @(posedge core_clk); while (hready !== 1'b1);
    rd = hrdata[15:0];
    hwdata <= ~hwdata;
  endtask
  // one-cycle {stop, wait, wake} request as a halt instruction gives it
  task automatic halt(input logic [2:0] swk);
    @(posedge core_clk);
    {core_stop_req, core_wait_req, wake_req} <= swk;
    @(posedge core_clk);
    {core_stop_req, core_wait_req, wake_req} <= 3'h0;
  endtask
endmodule

//--- verification/sgm_glue_monitor.sv
`include "sgm_consts.vh"
// ----------------------------------------------------------------------------
// power mode and clock gating checks at the block's pins
// ----------------------------------------------------------------------------
module sgm_glue_chk #(
  parameter RESET_HOLD_CYC = 4
) (
  input wire       core_clk,
  input wire       nrst,
  input wire       core_stop_req,
  input wire       core_wait_req,
  input wire       wake_req,
  input wire       tap_enabled,
  input wire [1:0] power_mode,
  input wire       core_clk_en,
  input wire       sys_clk_en,
  input wire       periph_clk_en,
  input wire       hs_periph_tick,
  input wire       i2c_clk_en,
  input wire       pwm_clk_en,
  input wire       dbg_clk_en,
  input wire       sys_rst_req
);
  logic [7:0] hold_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // length of the current reset request; counted here since the tools choke on long repeats
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) hold_q <= 8'h00;
    else if (sys_rst_req) hold_q <= hold_q + 8'h01;
    else hold_q <= 8'h00;
  end
  sequence run_left_s;
    $past(power_mode) == `SGM_MODE_RUN;
  endsequence
  sequence wake_s;
    power_mode != `SGM_MODE_RUN && wake_req;
  endsequence
  stop_entry_a: assert property (run_left_s ##0 power_mode == `SGM_MODE_STOP |->
    $past(core_stop_req)) else $error("stop mode entered without a stop request");
  wait_entry_a: assert property (run_left_s ##0 power_mode == `SGM_MODE_WAIT |->
    $past(core_wait_req)) else $error("wait mode entered without a wait request");
  wake_run_a: assert property (wake_s |=> power_mode == `SGM_MODE_RUN)
    else $error("wake request did not return to run");
  three_modes_a: assert property (power_mode != 2'h3)
    else $error("illegal power mode");
  stop_gate_a: assert property (power_mode == `SGM_MODE_STOP |-> !(core_clk_en | sys_clk_en |
    periph_clk_en | i2c_clk_en | pwm_clk_en | hs_periph_tick)) else $error("clock runs in stop");
  wait_gate_a: assert property (power_mode == `SGM_MODE_WAIT |-> !core_clk_en && periph_clk_en)
    else $error("wrong clock gating in wait");
  run_clocks_a: assert property (power_mode == `SGM_MODE_RUN |-> core_clk_en && sys_clk_en && periph_clk_en)
    else $error("clock stopped in run");
  dbg_clock_a: assert property (tap_enabled |-> dbg_clk_en)
    else $error("debug clock off while tap enabled");
  reset_hold_a: assert property ($fell(sys_rst_req) |-> hold_q == RESET_HOLD_CYC)
    else $error("software reset request has wrong length");
endmodule
bind sgm_sys_glue_module sgm_glue_chk #(.RESET_HOLD_CYC(RESET_HOLD_CYC)) chk_i (
  .core_clk, .nrst, .core_stop_req, .core_wait_req, .wake_req, .tap_enabled, .power_mode,
  .core_clk_en, .sys_clk_en, .periph_clk_en, .hs_periph_tick, .i2c_clk_en, .pwm_clk_en,
  .dbg_clk_en, .sys_rst_req);

//--- verification/tb.sv
`include "sgm_consts.vh"
// ----------------------------------------------------------------------------
// self-checking bench with a control register model
// ----------------------------------------------------------------------------
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HOLD = 3;
  localparam [15:0] IDH = 16'h1357;  // arbitrary value
  localparam [15:0] IDL = 16'h2468;  // arbitrary value
  logic        core_clk = 1'b0, nrst = 1'b0, por_nrst = 1'b0, pin_rst_req = 1'b0;
  logic        wdog_rst_req = 1'b0, tap_enabled = 1'b0, pwm_reload_sync = 1'b0;
  logic        tmr3_pin_in = 1'b0, hs_clk_sel = 1'b0;
  wire  [31:0] haddr, hwdata, hrdata;
  wire  [17:0] short_addr_loc;
  wire  [3:0]  tmr_ch_clk_en;
  wire  [2:0]  hsize;
  wire  [1:0]  htrans, power_mode;
  wire         hsel, hwrite, hreadyout, hresp, core_stop_req, core_wait_req, wake_req;
  wire         core_clk_en, sys_clk_en, periph_clk_en, hs_periph_tick, serial_clk_en;
  wire         i2c_clk_en, adc_clk_en, spi_clk_en, pwm_clk_en, dbg_clk_en, tmr_ch3_in;
  wire         sys_rst_req;
  logic [15:0] v, d, sc [4];
  logic [1:0]  e;
  logic [3:0]  ri [6] = '{4'h0, 4'h1, 4'hA, 4'h6, 4'h7, 4'h9};
  logic [15:0] re [6] = '{16'h0000, 16'h0004, `SGM_CLKOUT_RST, IDH, IDL, 16'h0000};
  int          ctrl_m, lk_s, lk_w, checks, error_cnt, cyc, n;
  sgm_sys_glue_module #(.RESET_HOLD_CYC(HOLD), .ID_UPPER(IDH), .ID_LOWER(IDL)) uut (
    .core_clk, .nrst, .por_nrst, .pin_rst_req, .wdog_rst_req, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .core_stop_req,
    .core_wait_req, .wake_req, .tap_enabled, .pwm_reload_sync, .tmr3_pin_in, .hs_clk_sel,
    .power_mode, .core_clk_en, .sys_clk_en, .periph_clk_en, .hs_periph_tick, .tmr_ch_clk_en,
    .serial_clk_en, .i2c_clk_en, .adc_clk_en, .spi_clk_en, .pwm_clk_en, .dbg_clk_en,
    .tmr_ch3_in, .sys_rst_req, .short_addr_loc, .regulator_standby(), .pin_route(),
    .clkout_ctl());
  sgm_core_model core (.core_clk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .core_stop_req, .core_wait_req, .wake_req);
  always #50 core_clk = ~core_clk;
  // a hung handshake ends the run here
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] i, input logic [15:0] wv);
    logic [15:0] x;
    core.xfer(1'b1, i, wv, x);
  endtask
  task automatic rd(input logic [3:0] i, input logic [15:0] ev);
    logic [15:0] x;
    core.xfer(1'b0, i, 16'h0000, x);
    chk($sformatf("reg %0h", i), x, ev);
  endtask
  // model keeps a locked field and still takes the other bits
  task automatic wctrl(input logic [15:0] wv);
    int m;
    m = wv & `SGM_CTRL_MASK;
    if (lk_s) m = (m & 16'hFFF3) | (ctrl_m & 16'h000C);
    if (lk_w) m = (m & 16'hFFFC) | (ctrl_m & 16'h0003);
    lk_s |= m[3];
    lk_w |= m[1];
    ctrl_m = m;
    wr(`SGM_IDX_CTRL, wv);
  endtask
  task automatic rst_pulse();
    @(posedge core_clk);
    nrst <= 1'b0;
    @(posedge core_clk);
    nrst <= 1'b1;
    {ctrl_m, lk_s, lk_w} = '0;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'h30A3));
    repeat (12) @(posedge core_clk);
    {por_nrst, nrst} <= 2'h3;
    for (int i = 0; i < 6; i++) begin
      rd(ri[i], re[i]);
      if (ri[i] inside {4'h1, 4'h6, 4'h7, 4'h9}) wr(ri[i], 16'hFFFF);
      rd(ri[i], re[i]);
    end
    $display("test reset values done");
    for (int k = 0; k < 8; k++) begin
      rst_pulse();
      wr(`SGM_IDX_PCE, 16'hFFFF);
      v = 16'($urandom & 32'hF000) | 16'h0800 | 16'(k < 4 ? k << 2 : k - 4);
      wctrl(v);
      core.halt(k < 4 ? 3'h4 : 3'h2);
      @(negedge core_clk);
      e = k[0] ? `SGM_MODE_RUN : (k < 4 ? `SGM_MODE_STOP : `SGM_MODE_WAIT);
      chk("mode", power_mode, e);
      if (e == `SGM_MODE_STOP) begin
        chk("tmr_stop", {tmr_ch_clk_en, serial_clk_en}, v[15:11]);
        chk("gated", {i2c_clk_en, adc_clk_en, spi_clk_en, pwm_clk_en, core_clk_en}, 0);
      end
      if (e == `SGM_MODE_WAIT) chk("wait_clk", {core_clk_en, pwm_clk_en}, 2'h1);
      core.halt(3'h1);
      @(negedge core_clk);
      chk("run", power_mode, `SGM_MODE_RUN);
      wctrl(~v & 16'hFFEF);
      rd(`SGM_IDX_CTRL, 16'(ctrl_m));
    end
    $display("test halt codes done");
    for (int j = 0; j < 4; j++) begin
      wctrl(16'(j[1] << 9) | 16'(j[0] << 5));
      @(posedge core_clk);
      {pwm_reload_sync, tmr3_pin_in, tap_enabled} <= 3'($urandom);
      @(negedge core_clk);
      chk("tc3_in", tmr_ch3_in, j[1] ? pwm_reload_sync : tmr3_pin_in);
      chk("dbg_clk", dbg_clk_en, j[0] | tap_enabled);
    end
    for (int s = 0; s < 2; s++) begin
      @(posedge core_clk);
      hs_clk_sel <= s[0];
      n = 0;
      repeat (9) begin
        @(negedge core_clk);
        n += (hs_periph_tick === 1'b1);
      end
      chk("hs_tick", n, s ? 9 : 3);
    end
    v = 16'($urandom);
    d = 16'($urandom);
    wr(`SGM_IDX_PCE, v);
    wr(`SGM_IDX_SAHI, v);
    wr(`SGM_IDX_SALO, d);
    @(negedge core_clk);
    chk("pce", {i2c_clk_en, adc_clk_en, tmr_ch_clk_en, serial_clk_en, spi_clk_en, pwm_clk_en},
        {v[15], v[13], {4{v[6]}}, v[4], v[2], v[0]});
    chk("short_addr", short_addr_loc, {v[1:0], d});
    rd(`SGM_IDX_PCE, v & `SGM_PCE_MASK);
    $display("test routing and gating done");
    for (int i = 0; i < 4; i++) begin
      sc[i] = 16'($urandom);
      wr(4'(`SGM_IDX_SWC0 + i), sc[i]);
    end
    rst_pulse();
    for (int i = 0; i < 4; i++) rd(4'(`SGM_IDX_SWC0 + i), sc[i]);
    $display("test scratch done");
    wctrl(16'h0010);
    for (int w = 0; w < 4 && sys_rst_req !== 1'b1; w++) @(negedge core_clk);
    n = 0;
    while (sys_rst_req === 1'b1 && n < 300) begin
      n++;
      @(negedge core_clk);
    end
    chk("rst_len", n, HOLD);
    rd(`SGM_IDX_CTRL, 16'(ctrl_m));
    rd(`SGM_IDX_RSTAT, 16'h0020);
    @(posedge core_clk);
    {pin_rst_req, wdog_rst_req} <= 2'h3;
    @(posedge core_clk);
    {pin_rst_req, wdog_rst_req} <= 2'h0;
    rd(`SGM_IDX_RSTAT, 16'h0008);
    $display("test software reset done");
    conclude();
  end
endmodule
